// ===== shared/srsr_defines.vh
`ifndef SRSR_DEFINES_VH
`define SRSR_DEFINES_VH
// ==========================================================
// Sequence counts
`define SRSR_OPT_LOAD_CYC 8'd50
`define SRSR_HOLD_OSC_CYC 8'd66
`define SRSR_SYS_HOLD_CYC 8'd16
`define SRSR_PIN_QUAL_CYC 8'd4
`define SRSR_RESET_VECTOR 24'h000004
// ==========================================================
// Register offsets and fields
`define SRSR_ADDR_STATUS 4'h0
`define SRSR_ADDR_CTRL 4'h1
`define SRSR_BIT_POR 7
`define SRSR_BIT_STOP 6
`define SRSR_BIT_WDT 5
`define SRSR_BIT_EXT 4
`define SRSR_BIT_FLT 3
`define SRSR_BIT_USR 2
`define SRSR_BIT_USER_RST 0
`define SRSR_CTRL_RESET 8'h00
`endif

// ===== core/srsr_reset_ctrl.v
`include "srsr_defines.vh"
module srsr_reset_ctrl #(
    parameter HOLD_OSC_CYC = 66,
    parameter OPT_LOAD_CYC = 50,
    parameter SYS_HOLD_CYC = 16,
    parameter PIN_QUAL_CYC = 4
) (
    input wire clk_sys_in,
    input wire rst_b_in,
    input wire osc_tick_in,
    input wire por_in,
    input wire brownout_detect_in,
    input wire brownout_stop_keepalive_in,
    input wire watchdog_timeout_in,
    input wire watchdog_reset_select_in,
    input wire fault_detect_in,
    input wire recovery_edge_in,
    input wire stop_mode_in,
    input wire reset_pin_in,
    input wire [3:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire reg_wr_debug_in,
    output reg [7:0] reg_rdata_out,
    output reg reset_pin_out,
    output reg reset_pin_oe_out,
    output reg core_reset_out,
    output reg periph_reset_out,
    output reg debug_reset_out,
    output reg sys_clk_en_out,
    output reg option_load_out,
    output reg gpio_force_input_out,
    output reg pwm_float_out,
    output reg pwm_off_state_out,
    output reg preserve_regs_out,
    output reg watchdog_exception_out,
    output reg [23:0] pc_load_value_out,
    output reg pc_load_out
);
// ==========================================================
// Sequencer states
localparam ST_RUN = 5'b00001;
localparam ST_HOLD = 5'b00010;
localparam ST_OPT = 5'b00100;
localparam ST_SYS = 5'b01000;
localparam ST_PIN = 5'b10000;

reg [4:0] state;
reg [7:0] osc_cnt;
reg [7:0] sys_cnt;
reg [7:0] pin_cnt;
reg [2:0] pin_sync;
reg pin_low;
reg stop_rec;
reg dbg_req;
reg wdt_exc_pend;
reg [5:0] status;
reg [5:0] cause;
reg [7:0] ctrl;
reg power_src;

// ==========================================================
// Pin input
// Three flops; a change counts once the last two agree.
always @(posedge clk_sys_in)
begin
    if (!rst_b_in)
    begin
        pin_sync <= 3'b111;
        pin_low <= 1'b0;
    end
    else
    begin
        pin_sync <= {pin_sync[1:0], reset_pin_in};
        if (pin_sync[2] == pin_sync[1])
        begin
            pin_low <= ~pin_sync[2];
        end
    end
end

// Stop mode has no clock to filter with, so the raw synchronised level counts.
wire pin_asserted = stop_mode_in ? pin_low : (pin_cnt >= PIN_QUAL_CYC);
wire bo_active = brownout_detect_in & (~stop_mode_in | brownout_stop_keepalive_in);
wire power_evt = por_in | bo_active;
wire wdt_rst = watchdog_timeout_in & watchdog_reset_select_in & ~stop_mode_in;
wire user_rst = reg_wr_in & (reg_addr_in == `SRSR_ADDR_STATUS)
    & reg_wdata_in[`SRSR_BIT_USER_RST];
wire sw_rst = user_rst & ~stop_mode_in;
wire sys_evt = power_evt | pin_asserted | fault_detect_in | wdt_rst | sw_rst;
wire smr_evt = stop_mode_in & (watchdog_timeout_in | recovery_edge_in);

// ==========================================================
// Sequencer
always @(posedge clk_sys_in)
begin
    if (!rst_b_in)
    begin
        state <= ST_HOLD;
        osc_cnt <= 8'h00;
        sys_cnt <= 8'h00;
        pin_cnt <= 8'h00;
        stop_rec <= 1'b0;
        dbg_req <= 1'b0;
        cause <= 6'h20;
        power_src <= 1'b1;
        status <= 6'h00;
        wdt_exc_pend <= 1'b0;
    end
    else
    begin
        if (!pin_low)
        begin
            pin_cnt <= 8'h00;
        end
        else if (pin_cnt < PIN_QUAL_CYC)
        begin
            pin_cnt <= pin_cnt + 8'h01;
        end
        if (sys_evt && (state == ST_RUN || power_evt))
        begin
            state <= ST_HOLD;
            osc_cnt <= 8'h00;
            sys_cnt <= 8'h00;
            stop_rec <= 1'b0;
            power_src <= power_evt;
            dbg_req <= sw_rst & reg_wr_debug_in & ~power_evt;
            // Priority: power, fault, pin, watchdog, software.
            // The cause word lines up with the status bits seven down to two.
            if (power_evt)
            begin
                cause <= 6'b100000;
            end
            else if (fault_detect_in)
            begin
                cause <= 6'b000010;
            end
            else if (pin_asserted)
            begin
                cause <= 6'b000100;
            end
            else if (wdt_rst)
            begin
                cause <= 6'b001000;
            end
            else
            begin
                cause <= 6'b000001;
            end
        end
        else if (smr_evt && state == ST_RUN)
        begin
            state <= ST_HOLD;
            osc_cnt <= 8'h00;
            sys_cnt <= 8'h00;
            stop_rec <= 1'b1;
            power_src <= 1'b0;
            dbg_req <= 1'b0;
            cause <= {1'b0, 1'b1, watchdog_timeout_in, 3'b000};
            wdt_exc_pend <= watchdog_timeout_in & ~watchdog_reset_select_in;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    wdt_exc_pend <= 1'b0;
                end
                ST_HOLD:
                begin
                    // Oscillator count; stop recovery skips option reload.
                    if (osc_tick_in)
                    begin
                        osc_cnt <= osc_cnt + 8'h01;
                    end
                    if (osc_tick_in && osc_cnt == OPT_LOAD_CYC - 1 && !stop_rec)
                    begin
                        state <= ST_OPT;
                    end
                    else if (osc_tick_in && osc_cnt == HOLD_OSC_CYC - 1)
                    begin
                        state <= ST_SYS;
                    end
                    if (power_src && bo_active)
                    begin
                        osc_cnt <= 8'h00;
                    end
                end
                ST_OPT:
                begin
                    if (osc_tick_in)
                    begin
                        osc_cnt <= osc_cnt + 8'h01;
                    end
                    if (osc_tick_in && osc_cnt == HOLD_OSC_CYC - 1)
                    begin
                        state <= ST_SYS;
                    end
                end
                ST_SYS:
                begin
                    if (pin_low)
                    begin
                        sys_cnt <= 8'h00;
                        state <= ST_PIN;
                    end
                    else if (sys_cnt == SYS_HOLD_CYC - 1)
                    begin
                        state <= ST_RUN;
                        status <= cause;
                    end
                    else
                    begin
                        sys_cnt <= sys_cnt + 8'h01;
                    end
                end
                ST_PIN:
                begin
                    // The count restarts while the line is low, so release follows the pin.
                    if (pin_low)
                    begin
                        sys_cnt <= 8'h00;
                    end
                    else if (sys_cnt == SYS_HOLD_CYC - 1)
                    begin
                        state <= ST_RUN;
                        status <= cause;
                    end
                    else
                    begin
                        sys_cnt <= sys_cnt + 8'h01;
                    end
                end
                default:
                begin
                    state <= ST_HOLD;
                end
            endcase
        end
    end
end

// ==========================================================
// Outputs
// The pin is pulled only for the oscillator part of the sequence. Pulling it
// through the system clock part would make the block read its own pull as an
// outside request and never leave reset.
wire in_reset = (state != ST_RUN);
wire osc_phase = (state == ST_HOLD) | (state == ST_OPT);
always @(posedge clk_sys_in)
begin
    if (!rst_b_in)
    begin
        reset_pin_out <= 1'b0;
        reset_pin_oe_out <= 1'b1;
        core_reset_out <= 1'b1;
        periph_reset_out <= 1'b1;
        debug_reset_out <= 1'b1;
        gpio_force_input_out <= 1'b1;
        preserve_regs_out <= 1'b0;
    end
    else
    begin
        reset_pin_out <= 1'b0;
        // Open drain: only ever pulls low, for internal sources too, but not during stop recovery.
        reset_pin_oe_out <= osc_phase & ~stop_rec;
        core_reset_out <= in_reset;
        periph_reset_out <= in_reset & ~stop_rec;
        debug_reset_out <= in_reset & ~stop_rec & ~dbg_req;
        gpio_force_input_out <= in_reset & ~stop_rec;
        preserve_regs_out <= stop_rec;
    end
end

// ==========================================================
// Clock, option load and motor outputs
always @(posedge clk_sys_in)
begin
    if (!rst_b_in)
    begin
        sys_clk_en_out <= 1'b0;
        option_load_out <= 1'b0;
        pwm_float_out <= 1'b1;
        pwm_off_state_out <= 1'b0;
    end
    else
    begin
        sys_clk_en_out <= (state == ST_SYS) | (state == ST_PIN) | (state == ST_RUN);
        option_load_out <= (state == ST_HOLD) & ~stop_rec;
        // Float until option bits are loaded, then drive the off level.
        pwm_float_out <= (state == ST_HOLD) & ~stop_rec;
        pwm_off_state_out <= ((state == ST_OPT) | (state == ST_SYS) | (state == ST_PIN))
            & ~stop_rec;
    end
end

// ==========================================================
// Vector load and deferred watchdog exception
always @(posedge clk_sys_in)
begin
    if (!rst_b_in)
    begin
        watchdog_exception_out <= 1'b0;
        pc_load_value_out <= `SRSR_RESET_VECTOR;
        pc_load_out <= 1'b0;
    end
    else
    begin
        watchdog_exception_out <= (state == ST_RUN) & wdt_exc_pend;
        pc_load_value_out <= `SRSR_RESET_VECTOR;
        pc_load_out <= (state == ST_SYS || state == ST_PIN) && !pin_low
            && (sys_cnt == SYS_HOLD_CYC - 1);
    end
end

// ==========================================================
// Register port
always @(posedge clk_sys_in)
begin
    if (!rst_b_in)
    begin
        ctrl <= `SRSR_CTRL_RESET;
        reg_rdata_out <= 8'h00;
    end
    else
    begin
        if (reg_wr_in && reg_addr_in == `SRSR_ADDR_CTRL)
        begin
            ctrl <= reg_wdata_in;
        end
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                `SRSR_ADDR_STATUS:
                begin
                    reg_rdata_out <= {status, 2'b00};
                end
                `SRSR_ADDR_CTRL:
                begin
                    reg_rdata_out <= ctrl;
                end
                default:
                begin
                    reg_rdata_out <= 8'h00;
                end
            endcase
        end
        else
        begin
            reg_rdata_out <= 8'h00;
        end
    end
end
endmodule // srsr_reset_ctrl

// ===== sim/srsr_chk.sv
module srsr_chk #(
    parameter int SYS_HOLD_CYC = 16
) (
    input wire clk_sys_in,
    input wire rst_b_in,
    input wire reset_pin_in,
    input wire stop_mode_in,
    input wire watchdog_timeout_in,
    input wire watchdog_reset_select_in,
    input wire reg_wr_in,
    input wire reg_wr_debug_in,
    input wire [3:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reset_pin_oe_out,
    input wire core_reset_out,
    input wire periph_reset_out,
    input wire debug_reset_out,
    input wire sys_clk_en_out,
    input wire option_load_out,
    input wire gpio_force_input_out,
    input wire pwm_off_state_out,
    input wire preserve_regs_out,
    input wire [23:0] pc_load_value_out,
    input wire pc_load_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hold_cnt;
    logic sw_wr;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);
    // ==========================================
    // Clocks seen while the core still waits; it restarts on every new sequence.
    always_ff @(posedge clk_sys_in)
        hold_cnt <= (sys_clk_en_out && core_reset_out) ? hold_cnt + 8'd1 : 8'd0;
    assign sw_wr = reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[0] && !core_reset_out;
    oe_drive_a: assert property (periph_reset_out && !sys_clk_en_out |-> reset_pin_oe_out && gpio_force_input_out)
        else $error("pin or gpio not held in reset");
    opt_first_a: assert property (sys_clk_en_out && periph_reset_out |-> !option_load_out && pwm_off_state_out)
        else $error("clock started during option load");
    core_hold_a: assert property ($fell(core_reset_out) && !$past(preserve_regs_out) |-> hold_cnt >= SYS_HOLD_CYC)
        else $error("core released too early");
    vector_a: assert property (pc_load_out |-> pc_load_value_out == 24'h000004 ##[0:2] !core_reset_out)
        else $error("bad vector load");
    wdog_a: assert property (watchdog_timeout_in && watchdog_reset_select_in && !stop_mode_in && !core_reset_out |-> ##[1:3] core_reset_out)
        else $error("watchdog reset missed");
    pin_qual_a: assert property ((!reset_pin_in && !reset_pin_oe_out) [*8] |-> ##[0:3] core_reset_out)
        else $error("pin reset missed");
    user_a: assert property (sw_wr && !stop_mode_in |-> ##[1:3] core_reset_out)
        else $error("software reset missed");
    dbg_keep_a: assert property (sw_wr && reg_wr_debug_in |=> !debug_reset_out [*4])
        else $error("debugger was reset");
    cover property (pc_load_out && preserve_regs_out);
    cover property ($fell(core_reset_out));
    cover property (sw_wr && reg_wr_debug_in);
endmodule // srsr_chk

// ===== sim/srsr_pin_party.sv
module srsr_pin_party (
    input wire clk_in,
    input wire dev_oe_in,
    input wire dev_out_in,
    input wire pull_req_in,
    output logic pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] low_cnt = 4'd0;
    // ==========================================
    // A board source keeps its low six clocks at least, however short the request.
    always @(posedge clk_in)
        low_cnt <= pull_req_in ? 4'd6 : (low_cnt == 4'd0 ? 4'd0 : low_cnt - 4'd1);
    // Open drain with a pull-up: high only once every party has let go.
    assign pin_out = !(pull_req_in || low_cnt != 4'd0 || (dev_oe_in && !dev_out_in));
endmodule // srsr_pin_party

// ===== sim/testbench.sv
bind srsr_reset_ctrl srsr_chk #(.SYS_HOLD_CYC(SYS_HOLD_CYC)) u_srsr_chk (.clk_sys_in, .rst_b_in,
    .reset_pin_in, .stop_mode_in, .watchdog_timeout_in, .watchdog_reset_select_in, .reg_wr_in,
    .reg_wr_debug_in, .reg_addr_in, .reg_wdata_in, .reset_pin_oe_out, .core_reset_out,
    .periph_reset_out, .debug_reset_out, .sys_clk_en_out, .option_load_out, .gpio_force_input_out,
    .pwm_off_state_out, .preserve_regs_out, .pc_load_value_out, .pc_load_out);
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SYS = 3;
    logic clk_sys_in = 1'b0, rst_b_in = 1'b0, osc_tick_in = 1'b0, por_in = 1'b0, pull_req = 1'b0;
    logic brownout_detect_in = 1'b0, watchdog_timeout_in = 1'b0, watchdog_reset_select_in = 1'b1;
    logic fault_detect_in = 1'b0, recovery_edge_in = 1'b0, stop_mode_in = 1'b0, reset_pin_in;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, reg_wr_debug_in = 1'b0, reset_pin_out, pc_load_out;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
    logic reset_pin_oe_out, core_reset_out, periph_reset_out, debug_reset_out, sys_clk_en_out;
    logic option_load_out, gpio_force_input_out, pwm_float_out, pwm_off_state_out;
    logic preserve_regs_out, watchdog_exception_out;
    logic [23:0] pc_load_value_out;
    logic [1:0] div = 2'd0;
    int n_fail = 0, checked = 0, cyc = 0;
    // Row: stop, power-on, brown-out, watchdog, fault, pin, user write, recovery edge, status.
    logic [15:0] rows [8] = '{16'h4080, 16'h2080, 16'h1020, 16'h0808, 16'h0410, 16'h0204,
        16'h8140, 16'h9060};
    srsr_reset_ctrl #(.HOLD_OSC_CYC(6), .OPT_LOAD_CYC(4), .SYS_HOLD_CYC(SYS), .PIN_QUAL_CYC(4))
    u_srsr_reset_ctrl (.clk_sys_in, .rst_b_in, .osc_tick_in, .por_in, .brownout_detect_in,
        .brownout_stop_keepalive_in(1'b1), .watchdog_timeout_in, .watchdog_reset_select_in,
        .fault_detect_in, .recovery_edge_in, .stop_mode_in, .reset_pin_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_wr_debug_in, .reg_rdata_out, .reset_pin_out,
        .reset_pin_oe_out, .core_reset_out, .periph_reset_out, .debug_reset_out, .sys_clk_en_out,
        .option_load_out, .gpio_force_input_out, .pwm_float_out, .pwm_off_state_out,
        .preserve_regs_out, .watchdog_exception_out, .pc_load_value_out, .pc_load_out);
    srsr_pin_party u_srsr_pin_party (.clk_in(clk_sys_in), .dev_oe_in(reset_pin_oe_out),
        .dev_out_in(reset_pin_out), .pull_req_in(pull_req), .pin_out(reset_pin_in));
    // ==========================================
    initial
    begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // The oscillator ticks every fourth clock; the ceiling is far above a full run.
    always @(posedge clk_sys_in)
    begin
        div <= div + 2'd1;
        osc_tick_in <= div == 2'd3;
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        n_fail += (seen !== exp);
        if (seen !== exp)
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clk_sys_in);
        {reg_wr_in, reg_addr_in, reg_wdata_in, reg_wr_debug_in} <= {1'b1, a, d, dbg};
        @(posedge clk_sys_in);
        {reg_wr_in, reg_wr_debug_in} <= 2'b00;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        {reg_rd_in, reg_addr_in} <= {1'b1, a};
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 check(reg_rdata_out, exp);
    endtask
    task automatic wait_rel();
        for (int k = 0; k < 400 && pc_load_out !== 1'b1; k++)
            @(posedge clk_sys_in) #1;
        check(pc_load_out, 1'b1);
        check(pc_load_value_out, 24'h000004);
        stop_mode_in <= 1'b0;
    endtask
    task automatic fire(input logic [7:0] ev);
        @(posedge clk_sys_in);
        {stop_mode_in, por_in, brownout_detect_in, watchdog_timeout_in, fault_detect_in,
            pull_req, reg_wr_in, recovery_edge_in} <= ev;
        {reg_addr_in, reg_wdata_in} <= 12'h001;
        @(posedge clk_sys_in);
        {por_in, brownout_detect_in, watchdog_timeout_in, fault_detect_in, pull_req, reg_wr_in,
            recovery_edge_in} <= 7'h00;
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        #1 check(reset_pin_oe_out, 1'b1);
        check(gpio_force_input_out, 1'b1);
        check(pwm_float_out, 1'b1);
        wait_rel();
        rd(4'h0, 8'h80);
        rd(4'h1, 8'h00);
        wr(4'h1, 8'h5a, 1'b0);
        rd(4'h1, 8'h5a);
        rd(4'hf, 8'h00);
        foreach (rows[i])
        begin
            fire(rows[i][15:8]);
            wait_rel();
            rd(4'h0, rows[i][7:0]);
        end
        watchdog_reset_select_in <= 1'b0;
        fire(8'h90);
        wait_rel();
        @(posedge clk_sys_in) #1 check(watchdog_exception_out, 1'b1);
        rd(4'h0, 8'h60);
        fire(8'h10);
        repeat (20) @(posedge clk_sys_in);
        #1 check(core_reset_out, 1'b0);
        watchdog_reset_select_in <= 1'b1;
        fire(8'h82);
        repeat (20) @(posedge clk_sys_in);
        #1 check(core_reset_out, 1'b0);
        stop_mode_in <= 1'b0;
        wr(4'h0, 8'h01, 1'b1);
        repeat (6) @(posedge clk_sys_in);
        #1 check(core_reset_out, 1'b1);
        check(debug_reset_out, 1'b0);
        wait_rel();
        rd(4'h0, 8'h04);
        pull_req <= 1'b1;
        repeat (80) @(posedge clk_sys_in);
        #1 check(core_reset_out, 1'b1);
        pull_req <= 1'b0;
        repeat (SYS + 6) @(posedge clk_sys_in);
        #1 check(core_reset_out, 1'b1);
        wait_rel();
        rd(4'h0, 8'h10);
        brownout_detect_in <= 1'b1;
        repeat (60) @(posedge clk_sys_in);
        #1 check(core_reset_out, 1'b1);
        brownout_detect_in <= 1'b0;
        wait_rel();
        rd(4'h0, 8'h80);
        tally_and_finish();
    end
endmodule // testbench
